/* File: bma_pkg.sv */
// Purpose: Constants, register map and states of the boot entry block
// Assumes: 50 MHz system clock, 16-bit register port
// Notes:   Offsets are byte addresses on the register port
`default_nettype none
package bma_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned READY_STATES    = 100;
    localparam int unsigned ZERO_BYTE_BITS  = 9;
    localparam int          CNT_W           = 18;
    localparam int          DIV_W           = 16;
    localparam logic [CNT_W-1:0] READY_CYC  = CNT_W'(READY_STATES - 1);
    localparam logic [CNT_W-1:0] BIT_DIV    = CNT_W'(ZERO_BYTE_BITS);
    localparam logic [CNT_W-1:0] CNT_MAX    = {CNT_W{1'b1}};
    localparam logic [3:0]  START_IDX       = 4'h0;
    localparam logic [3:0]  STOP_IDX        = 4'h9;
    // ==========================================================
    // Bytes and addresses
    localparam logic [7:0]  ADJ_DONE_BYTE   = 8'h00;
    localparam logic [7:0]  SYNC_BYTE       = 8'h55;
    localparam logic [23:0] BRANCH_ADDR     = 24'hFF_E720;
    // ==========================================================
    // Register map
    localparam logic [7:0]  SCR_OFS         = 8'h00;
    localparam logic [7:0]  BDIV_OFS        = 8'h02;
    localparam logic [7:0]  P9DIR_OFS       = 8'h04;
    localparam logic [7:0]  P9OUT_OFS       = 8'h06;
    localparam logic [7:0]  LLEN_OFS        = 8'h08;
    localparam logic [7:0]  STAT_OFS        = 8'h0A;
    localparam int          TX_ON_BIT       = 5;
    localparam int          RX_ON_BIT       = 4;
    localparam int          TXPIN_BIT       = 1;
    localparam logic [7:0]  SCR_RST         = 8'h00;
    localparam logic [7:0]  P9_RST          = 8'h00;
    localparam logic [DIV_W-1:0] BDIV_RST   = 16'h0001;
    localparam logic [15:0] LLEN_RST        = 16'h0100;
    // ==========================================================
    // Boot sequence, Gray coded along the usual path
    typedef enum logic [3:0] {
        S_READY = 4'b0000,
        S_MWAIT = 4'b0001,
        S_MLOW  = 4'b0011,
        S_DIV   = 4'b0010,
        S_SEND  = 4'b0110,
        S_SYNC  = 4'b0111,
        S_ERASE = 4'b0101,
        S_LOAD  = 4'b0100,
        S_HAND  = 4'b1100,
        S_RUN   = 4'b1101,
        S_USER  = 4'b1111
    } bma_state_t;
endpackage : bma_pkg
`default_nettype wire

/* File: bma_boot_entry.sv */
// Purpose: Boot mode entry with serial bit-rate auto adjustment
// Assumes: Host link pulled up; flash eraser and RAM sit outside
// Notes:   One clock domain; pins pass two flip-flops first
//
// Behaviour
// - In boot mode, time the low period of host zero bytes on receive line.
// - Serial format is eight data bits, one stop bit, no parity.
// - After computing the rate, send one zero byte to the host.
// - Clock must suit the host rate: 16/8/4 to 25 MHz; this block assumes a 50 MHz clock.
// - About 100 states after reset pass before timing starts.
// - Erase all flash blocks when any flash location is programmed.
// - Before hand-over clear receive and transmit enables; divisor stays.
// - At hand-over transmit pin is a high output, direction and data set.
// - At hand-over general registers undefined, other registers unchanged.
// - Watchdog reset in boot mode restarts the boot program, state kept.
// - After the program is loaded, branch to address 0xFFE720.
`default_nettype none
module bma_boot_entry
    import bma_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_I,
    // Register port
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [15:0] REG_RDATA_O,
    // Serial pins
    input  wire logic        SERIAL_RX_PIN_I,
    output logic             SERIAL_TX_PIN_O,
    output logic             SERIAL_TX_OE_O,
    // Mode pins and watchdog
    input  wire logic        MODE_SELECT_PIN_0_I,
    input  wire logic        MODE_SELECT_PIN_2_I,
    input  wire logic        FLASH_WRITE_ENABLE_PIN_I,
    input  wire logic        WDT_RESET_I,
    // Flash eraser
    input  wire logic        FLASH_BLANK_I,
    input  wire logic        FLASH_ERASE_DONE_I,
    output logic             FLASH_ERASE_O,
    // RAM loader and hand-over
    output logic             RAM_WR_O,
    output logic      [15:0] RAM_ADDR_O,
    output logic      [7:0]  RAM_DATA_O,
    output logic             BRANCH_O,
    output logic      [23:0] BRANCH_ADDR_O,
    output logic             BOOT_MODE_O
);

    function automatic logic is_boot(input logic [2:0] p);
        // p = {write enable, mode 2, mode 0}
        return p[2] & ~p[1] & p[0];
    endfunction

    function automatic logic hit(input logic [7:0] ofs);
        return REG_ADDR_I == ofs;
    endfunction

    bma_state_t       state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [DIV_W-1:0] quot_r;
    logic [2:0]       pin_s1_r, pin_s2_r;
    logic             rx_s1_r, rx_s2_r, rx_d_r, rx_fall;
    logic             boot_r, taken_r;
    logic [7:0]       scr_r, p9dir_r, p9out_r;
    logic [DIV_W-1:0] bdiv_r;
    logic [15:0]      llen_r;
    logic             tx_go_r, tx_done_r, tx_busy_r, tx_line_r;
    logic [DIV_W-1:0] tx_tmr_r;
    logic [3:0]       tx_bit_r;
    logic [8:0]       tx_sh_r;
    logic             rx_busy_r, rx_vld_r;
    logic [DIV_W-1:0] rx_tmr_r;
    logic [3:0]       rx_bit_r;
    logic [7:0]       rx_sh_r, rx_byte_r;
    logic             rx_on, tx_on, div_done;

    assign rx_on    = scr_r[RX_ON_BIT];
    assign tx_on    = scr_r[TX_ON_BIT];
    assign rx_fall  = rx_d_r & ~rx_s2_r;
    assign div_done = (state_r == S_DIV) && (cnt_r < BIT_DIV);

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rx_s1_r  <= 1'b1;
            rx_s2_r  <= 1'b1;
            rx_d_r   <= 1'b1;
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            rx_s1_r  <= SERIAL_RX_PIN_I;
            rx_s2_r  <= rx_s1_r;
            rx_d_r   <= rx_s2_r;
            pin_s1_r <= {FLASH_WRITE_ENABLE_PIN_I, MODE_SELECT_PIN_2_I, MODE_SELECT_PIN_0_I};
            pin_s2_r <= pin_s1_r;
        end
    end

    // ==========================================================
    // Boot sequence
    // Mode pins are caught once, after the ready wait; a watchdog restart
    // keeps that decision, so later pin changes do not matter.
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r <= S_READY;
            cnt_r   <= '0;
            quot_r  <= '0;
            boot_r  <= 1'b0;
            taken_r <= 1'b0;
        end else if (WDT_RESET_I && boot_r) begin
            state_r <= S_READY;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                S_READY: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == READY_CYC) begin
                        cnt_r   <= '0;
                        taken_r <= 1'b1;
                        if (!taken_r) begin
                            boot_r  <= is_boot(pin_s2_r);
                            state_r <= is_boot(pin_s2_r) ? S_MWAIT : S_USER;
                        end else begin
                            state_r <= boot_r ? S_MWAIT : S_USER;
                        end
                    end
                end
                S_MWAIT: begin
                    // Line must be seen high first, so a byte already under
                    // way at the end of the wait is not timed
                    if (rx_fall) begin
                        cnt_r   <= CNT_W'(1);
                        state_r <= S_MLOW;
                    end
                end
                S_MLOW: begin
                    if (rx_s2_r) begin
                        quot_r  <= '0;
                        state_r <= S_DIV;
                    end else if (cnt_r != CNT_MAX) begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                S_DIV: begin
                    // Divide by repeated subtraction of BIT_DIV; costs one clock per quotient step, about one bit time
                    if (div_done) begin
                        state_r <= S_SEND;
                    end else begin
                        cnt_r  <= cnt_r - BIT_DIV;
                        quot_r <= quot_r + 1'b1;
                    end
                end
                S_SEND: begin
                    if (tx_done_r) begin
                        state_r <= S_SYNC;
                    end
                end
                S_SYNC: begin
                    // Leftover zero bytes from the host are skipped here
                    cnt_r <= '0;
                    if (rx_vld_r && rx_byte_r == SYNC_BYTE) begin
                        state_r <= FLASH_BLANK_I ? S_LOAD : S_ERASE;
                    end
                end
                S_ERASE: begin
                    if (FLASH_ERASE_DONE_I) begin
                        state_r <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    if (llen_r == '0) begin
                        state_r <= S_HAND;
                    end else if (rx_vld_r) begin
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r[15:0] == llen_r - 1'b1) begin
                            state_r <= S_HAND;
                        end
                    end
                end
                S_HAND:  state_r <= S_RUN;
                S_RUN:   state_r <= S_RUN;
                S_USER:  state_r <= S_USER;
                default: state_r <= S_READY;
            endcase
        end
    end

    // ==========================================================
    // Flash erase request, RAM loader and branch
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            FLASH_ERASE_O <= 1'b0;
            RAM_WR_O      <= 1'b0;
            RAM_ADDR_O    <= '0;
            RAM_DATA_O    <= '0;
            BRANCH_O      <= 1'b0;
        end else begin
            FLASH_ERASE_O <= (state_r == S_ERASE) && !FLASH_ERASE_DONE_I;
            RAM_WR_O      <= (state_r == S_LOAD) && rx_vld_r && (llen_r != '0);
            RAM_ADDR_O    <= cnt_r[15:0];
            RAM_DATA_O    <= rx_byte_r;
            BRANCH_O      <= (state_r == S_HAND);
        end
    end

    assign BRANCH_ADDR_O = BRANCH_ADDR;
    assign BOOT_MODE_O   = boot_r;

    // ==========================================================
    // Registers; hardware updates take priority over software
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            scr_r <= SCR_RST;
        end else if (div_done) begin
            scr_r[RX_ON_BIT] <= 1'b1;
            scr_r[TX_ON_BIT] <= 1'b1;
        end else if (state_r == S_HAND) begin
            scr_r[RX_ON_BIT] <= 1'b0;
            scr_r[TX_ON_BIT] <= 1'b0;
        end else if (REG_WR_I && hit(SCR_OFS)) begin
            scr_r <= REG_WDATA_I[7:0];
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bdiv_r <= BDIV_RST;
        end else if (div_done) begin
            bdiv_r <= (quot_r == '0) ? BDIV_RST : quot_r;
        end else if (REG_WR_I && hit(BDIV_OFS)) begin
            bdiv_r <= REG_WDATA_I;
        end
    end

    // Nothing else is touched at hand-over; CPU registers are outside
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            p9dir_r <= P9_RST;
            p9out_r <= P9_RST;
        end else if (state_r == S_HAND) begin
            p9dir_r[TXPIN_BIT] <= 1'b1;
            p9out_r[TXPIN_BIT] <= 1'b1;
        end else begin
            if (REG_WR_I && hit(P9DIR_OFS)) begin
                p9dir_r <= REG_WDATA_I[7:0];
            end
            if (REG_WR_I && hit(P9OUT_OFS)) begin
                p9out_r <= REG_WDATA_I[7:0];
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            llen_r <= LLEN_RST;
        end else if (REG_WR_I && hit(LLEN_OFS)) begin
            llen_r <= REG_WDATA_I;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            REG_RDATA_O <= '0;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                SCR_OFS:   REG_RDATA_O <= {8'h00, scr_r};
                BDIV_OFS:  REG_RDATA_O <= bdiv_r;
                P9DIR_OFS: REG_RDATA_O <= {8'h00, p9dir_r};
                P9OUT_OFS: REG_RDATA_O <= {8'h00, p9out_r};
                LLEN_OFS:  REG_RDATA_O <= llen_r;
                STAT_OFS:  REG_RDATA_O <= {9'h000, state_r, boot_r, tx_busy_r, rx_busy_r};
                default:   REG_RDATA_O <= '0;
            endcase
        end
    end

    // ==========================================================
    // Transmitter: start, eight data bits, one stop bit
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tx_go_r   <= 1'b0;
            tx_done_r <= 1'b0;
            tx_busy_r <= 1'b0;
            tx_line_r <= 1'b1;
            tx_tmr_r  <= '0;
            tx_bit_r  <= '0;
            tx_sh_r   <= '1;
        end else begin
            tx_go_r   <= div_done;
            tx_done_r <= 1'b0;
            if (!tx_on) begin
                tx_busy_r <= 1'b0;
                tx_line_r <= 1'b1;
            end else if (tx_go_r && !tx_busy_r) begin
                tx_sh_r   <= {1'b1, ADJ_DONE_BYTE};
                tx_line_r <= 1'b0;
                tx_busy_r <= 1'b1;
                tx_bit_r  <= START_IDX;
                tx_tmr_r  <= bdiv_r - 1'b1;
            end else if (tx_busy_r) begin
                if (tx_tmr_r != '0) begin
                    tx_tmr_r <= tx_tmr_r - 1'b1;
                end else if (tx_bit_r == STOP_IDX) begin
                    tx_busy_r <= 1'b0;
                    tx_done_r <= 1'b1;
                end else begin
                    tx_line_r <= tx_sh_r[0];
                    tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
                    tx_bit_r  <= tx_bit_r + 1'b1;
                    tx_tmr_r  <= bdiv_r - 1'b1;
                end
            end
        end
    end

    // Port data drives the pin once the serial transmitter is off
    assign SERIAL_TX_PIN_O = tx_on ? tx_line_r : p9out_r[TXPIN_BIT];
    assign SERIAL_TX_OE_O  = tx_on | p9dir_r[TXPIN_BIT];

    // ==========================================================
    // Receiver: samples mid-bit; a byte with a bad stop bit is dropped
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rx_busy_r <= 1'b0;
            rx_vld_r  <= 1'b0;
            rx_tmr_r  <= '0;
            rx_bit_r  <= '0;
            rx_sh_r   <= '0;
            rx_byte_r <= '0;
        end else begin
            rx_vld_r <= 1'b0;
            if (!rx_on) begin
                rx_busy_r <= 1'b0;
            end else if (!rx_busy_r) begin
                if (rx_fall) begin
                    rx_busy_r <= 1'b1;
                    rx_bit_r  <= START_IDX;
                    rx_tmr_r  <= bdiv_r >> 1;
                end
            end else if (rx_tmr_r != '0) begin
                rx_tmr_r <= rx_tmr_r - 1'b1;
            end else begin
                rx_tmr_r <= bdiv_r - 1'b1;
                rx_bit_r <= rx_bit_r + 1'b1;
                if (rx_bit_r == START_IDX && rx_s2_r) begin
                    rx_busy_r <= 1'b0;
                end else if (rx_bit_r == STOP_IDX) begin
                    rx_busy_r <= 1'b0;
                    rx_vld_r  <= rx_s2_r;
                    rx_byte_r <= rx_sh_r;
                end else if (rx_bit_r != START_IDX) begin
                    rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
                end
            end
        end
    end

endmodule : bma_boot_entry
`default_nettype wire

/* File: bma_boot_entry_assertions.sv */
// Purpose: Port-level checks of the boot entry block
// Assumes: One clock, reset active high
// Notes:   Bound to the block below
`default_nettype none
module bma_boot_entry_assertions
    import bma_pkg::*;
(
    // Clock and reset
    input wire logic        CLOCK_I,
    input wire logic        RESET_I,
    // Watched ports
    input wire logic        REG_RD_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic        SERIAL_TX_PIN_O,
    input wire logic        SERIAL_TX_OE_O,
    input wire logic        WDT_RESET_I,
    input wire logic        FLASH_ERASE_DONE_I,
    input wire logic        FLASH_ERASE_O,
    input wire logic        RAM_WR_O,
    input wire logic        BRANCH_O,
    input wire logic [23:0] BRANCH_ADDR_O,
    input wire logic        BOOT_MODE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    // ==========================================================
    // Cycles since reset release, saturating
    logic [7:0] since_rst_r;
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) since_rst_r <= 8'h00;
        else if (since_rst_r != 8'hFF) since_rst_r <= since_rst_r + 8'h01;
    end
    // ==========================================================
    // Properties
    a_ready_wait: assert property (BOOT_MODE_O |-> since_rst_r >= 8'h63)
        else $error("boot mode decided before the ready wait");
    a_branch_addr: assert property (BRANCH_ADDR_O == BRANCH_ADDR)
        else $error("branch address wrong");
    a_branch_pulse: assert property (BRANCH_O |=> !BRANCH_O)
        else $error("branch pulse longer than one cycle");
    a_branch_in_boot: assert property (BRANCH_O || RAM_WR_O |-> BOOT_MODE_O)
        else $error("load or branch outside boot mode");
    a_handover_pin: assert property (BRANCH_O |-> SERIAL_TX_PIN_O && SERIAL_TX_OE_O)
        else $error("transmit pin not a high output at hand-over");
    a_erase_hold: assert property (FLASH_ERASE_O && !FLASH_ERASE_DONE_I |=> FLASH_ERASE_O)
        else $error("erase request dropped early");
    a_erase_drop: assert property (FLASH_ERASE_O && FLASH_ERASE_DONE_I |=> !FLASH_ERASE_O)
        else $error("erase request kept after done");
    a_wdt_keeps: assert property (BOOT_MODE_O && WDT_RESET_I |=> BOOT_MODE_O)
        else $error("watchdog reset cleared boot mode");
    a_rdata_hold: assert property (!$past(REG_RD_I) |-> $stable(REG_RDATA_O))
        else $error("read data changed without a read");
endmodule // bma_boot_entry_assertions

bind bma_boot_entry bma_boot_entry_assertions i_chk (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .SERIAL_TX_PIN_O(SERIAL_TX_PIN_O), .SERIAL_TX_OE_O(SERIAL_TX_OE_O),
    .WDT_RESET_I(WDT_RESET_I), .FLASH_ERASE_DONE_I(FLASH_ERASE_DONE_I),
    .FLASH_ERASE_O(FLASH_ERASE_O), .RAM_WR_O(RAM_WR_O), .BRANCH_O(BRANCH_O),
    .BRANCH_ADDR_O(BRANCH_ADDR_O), .BOOT_MODE_O(BOOT_MODE_O)
);
`default_nettype wire

/* File: bma_host_model.sv */
// Purpose: Behavioural host on the boot serial link
// Assumes: 8N1 framing, LSB first
// Notes:   Bit time counted in system clocks
`default_nettype none
module bma_host_model #(
    parameter int BIT_CYC = 2604
) (
    input  wire logic clk_i,
    input  wire logic line_from_dev_i,
    output logic      line_to_dev_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_to_dev_o = 1'b1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            line_to_dev_o <= frame[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask

    // Samples mid-bit; ok is low on a missing start or stop bit
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'hFF;
        while (line_from_dev_i !== 1'b0 && n < 60000) begin
            @(posedge clk_i);
            n++;
        end
        if (n < 60000) begin
            repeat (BIT_CYC / 2) @(posedge clk_i);
            ok = (line_from_dev_i === 1'b0);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk_i);
                b[i] = line_from_dev_i;
            end
            repeat (BIT_CYC) @(posedge clk_i);
            ok = ok && (line_from_dev_i === 1'b1);
        end
    endtask
endmodule // bma_host_model
`default_nettype wire

/* File: bma_boot_entry_tb.sv */
// Purpose: Self-checking bench of the boot entry block
// Assumes: Host at 19200 bps on a 50 MHz clock
// Notes:   Load length cut to one byte to keep the run short
`default_nettype none
module bma_boot_entry_tb;
    import bma_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = 2604;
    logic        clock, reset, reg_wr, reg_rd, tx_pin, tx_oe, wdt, erase_done;
    logic        erase, ram_wr, branch, boot_mode, erase_seen;
    logic        mode0, mode2, flash_write_enable_pin, flash_blank;
    logic [7:0]  reg_addr, ram_data, ram_data_seen;
    logic [15:0] reg_wdata, reg_rdata, ram_addr, ram_addr_seen, div_keep;
    logic [23:0] branch_addr;
    logic [4:0]  erase_cnt;
    wire logic   rx_line;
    wire logic   tx_line = tx_oe ? tx_pin : 1'b1;
    int          mismatches, n_compared, ram_writes;

    bma_boot_entry i_dut (
        .CLOCK_I(clock), .RESET_I(reset), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
        .SERIAL_RX_PIN_I(rx_line), .SERIAL_TX_PIN_O(tx_pin), .SERIAL_TX_OE_O(tx_oe),
        .MODE_SELECT_PIN_0_I(mode0), .MODE_SELECT_PIN_2_I(mode2),
        .FLASH_WRITE_ENABLE_PIN_I(flash_write_enable_pin), .WDT_RESET_I(wdt),
        .FLASH_BLANK_I(flash_blank), .FLASH_ERASE_DONE_I(erase_done), .FLASH_ERASE_O(erase),
        .RAM_WR_O(ram_wr), .RAM_ADDR_O(ram_addr), .RAM_DATA_O(ram_data),
        .BRANCH_O(branch), .BRANCH_ADDR_O(branch_addr), .BOOT_MODE_O(boot_mode)
    );
    bma_host_model #(.BIT_CYC(BIT_CYC)) i_host (
        .clk_i(clock), .line_from_dev_i(tx_line), .line_to_dev_o(rx_line)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ==========================================================
    // Flash eraser stand-in and output monitors
    always @(posedge clock) begin
        erase_done <= 1'b0;
        if (erase && !erase_done) begin
            erase_cnt <= erase_cnt + 5'h01;
            if (erase_cnt == 5'h1F) erase_done <= 1'b1;
        end
    end
    always @(negedge clock) begin
        if (erase) erase_seen = 1'b1;
        if (ram_wr) begin
            ram_writes++;
            ram_addr_seen = ram_addr;
            ram_data_seen = ram_data;
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic conclude;
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ready_wdt;
        logic [15:0] d;
        repeat (150) @(posedge clock);
        reg_read(STAT_OFS, d);
        check(d[6:2], {S_MWAIT, 1'b1});
        reg_write(LLEN_OFS, 16'h0001);
        @(posedge clock) wdt <= 1'b1;
        @(posedge clock) wdt <= 1'b0;
        reg_read(STAT_OFS, d);
        check(d[6:2], {S_READY, 1'b1});
        repeat (60) @(posedge clock);
        reg_read(STAT_OFS, d);
        check(d[6:3], S_READY);
        reg_read(LLEN_OFS, d);
        check(d, 16'h0001);
        repeat (60) @(posedge clock);
        reg_read(STAT_OFS, d);
        check(d[6:3], S_MWAIT);
    endtask
    task automatic t_autobaud;
        logic [7:0] b;
        logic       ok;
        logic [15:0] d;
        fork
            i_host.send_byte(8'h00);
            i_host.recv_byte(b, ok);
        join
        check(ok, 1'b1);
        check(b, ADJ_DONE_BYTE);
        reg_read(BDIV_OFS, div_keep);
        check(div_keep >= 16'h0A2A && div_keep <= 16'h0A2E, 1'b1);
        reg_read(SCR_OFS, d);
        check(d[5:4], 2'b11);
    endtask
    task automatic t_load;
        logic [15:0] d;
        int          n;
        n = 0;
        // Branch is a one-cycle pulse inside the last stop bit: watch it while sending
        fork
            begin
                i_host.send_byte(SYNC_BYTE);
                i_host.send_byte(8'hA5);
            end
            begin
                while (branch !== 1'b1 && n < 60000) begin
                    @(negedge clock);
                    n++;
                end
                check(branch, 1'b1);
                check({tx_oe, tx_pin}, 2'b11);
            end
        join
        check(branch_addr, 24'hFF_E720);
        check(erase_seen, 1'b1);
        check({ram_writes[7:0], ram_addr_seen, ram_data_seen}, 32'h0100_00A5);
        reg_read(SCR_OFS, d);
        check(d[5:4], 2'b00);
        reg_read(BDIV_OFS, d);
        check(d, div_keep);
        reg_read(P9DIR_OFS, d);
        check(d[1], 1'b1);
        reg_read(P9OUT_OFS, d);
        check(d[1], 1'b1);
        reg_read(LLEN_OFS, d);
        check(d, 16'h0001);
        reg_read(8'h3C, d);
        check(d, 16'h0000);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        wdt = 1'b0;
        mode0 = 1'b1;
        mode2 = 1'b0;
        flash_write_enable_pin = 1'b1;
        flash_blank = 1'b0;
        erase_done = 1'b0;
        erase_cnt = 5'h00;
        erase_seen = 1'b0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        t_ready_wdt;
        t_autobaud;
        t_load;
        conclude;
    end
    initial begin
        // Three host bytes and one reply byte at the host rate plus timing, about 103k cycles
        #2_200_000;
        mismatches++;
        conclude;
    end
endmodule // bma_boot_entry_tb
`default_nettype wire
